// File: hw/pqu_map.vh
`ifndef PQU_MAP_VH
`define PQU_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Operation codes on the issue port
`define PQU_OP_W        3
`define PQU_OP_PAIR     3'h0
`define PQU_OP_ACC      3'h1
`define PQU_OP_DED      3'h2
`define PQU_OP_GPR      3'h3
`define PQU_OP_QUO      3'h4
`define PQU_OP_MFU      3'h5
`define PQU_OP_MFB      3'h6

////////////////////////////////////////////////////////////////////////////////
// Multiplier pass geometry
`define PQU_MCAND_W     33
`define PQU_MPLIER_W    17
`define PQU_PROD_W      50
`define PQU_DIGITS      9

////////////////////////////////////////////////////////////////////////////////
// Early-in divide: skipped iterations and total latency in clocks
`define PQU_DIV_BITS    6'h20
`define PQU_SKIP8       6'h17
`define PQU_SKIP16      6'h0F
`define PQU_SKIP24      6'h07
`define PQU_SKIP32      6'h00
`define PQU_LAT8        6'h0C
`define PQU_LAT16       6'h13
`define PQU_LAT24       6'h1A
`define PQU_LAT32       6'h21

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define PQU_RST_WORD    32'h00000000
`define PQU_RST_DEST    5'h00

`endif

// File: hw/pqu_mul_pass.v
`timescale 1ns/1ps
`include "pqu_map.vh"

module pqu_mul_pass (
  input  wire [`PQU_MCAND_W-1:0]  mcand,  // 32-bit side, sign or zero extended
  input  wire [`PQU_MPLIER_W-1:0] mplier, // 16-bit side, sign or zero extended
  output reg  [`PQU_PROD_W-1:0]   prod    // Signed product
);

  reg [`PQU_PROD_W-1:0] mext;
  reg [`PQU_PROD_W-1:0] pp;
  reg [`PQU_MPLIER_W+1:0] bx;
  reg [2:0]             trip;
  integer               i;

  ////////////////////////////////////////////////////////////////////////////
  // Radix-4 recoded partial products
  always @* begin
    mext = {{(`PQU_PROD_W-`PQU_MCAND_W){mcand[`PQU_MCAND_W-1]}}, mcand};
    bx   = {mplier[`PQU_MPLIER_W-1], mplier, 1'b0};
    prod = {`PQU_PROD_W{1'b0}};
    pp   = {`PQU_PROD_W{1'b0}};
    trip = 3'h0;
    for (i = 0; i < `PQU_DIGITS; i = i + 1) begin
      trip = bx[2*i +: 3];
      case (trip)
        3'h1, 3'h2: pp = mext;
        3'h3:       pp = mext << 1;
        3'h4:       pp = -(mext << 1);
        3'h5, 3'h6: pp = -mext;
        default:    pp = {`PQU_PROD_W{1'b0}};
      endcase
      prod = prod + (pp << (2*i));
    end
  end

endmodule // pqu_mul_pass

// File: hw/pqu_top.v
// Contract
// - The unit runs its own pipeline and keeps progressing whatever the integer pipeline does.
// - Products use a 32x16 recoded multiplier, first operand on the wide side, second on the narrow.
// - Short second operands pass the multiplier once, full 32-bit ones pass it twice.
// - A short multiply may issue every clock, a full multiply only every other clock.
// - The operand size is found from the operand values and issue_signed.
// - Division is iterative and yields one quotient bit per clock.
// - The divider skips 23, 15 or 7 iterations for 8, 16 or 24-bit dividends.
// - Any new issue is held off while a division runs, until its finishing clock.
// - Pair multiplies take 1/1 or 2/2 latency/repeat, the register-targeted one 2/1 or 3/2.
// - Divides take 12/11, 19/18, 26/25 or 33/32 latency/repeat by dividend size.
// - Results other than the register-targeted product land in the upper/bottom pair and move operations copy either half out.
// - The register-targeted multiply sends the low product word to a chosen register.
// - The accumulate multiply adds the product to the pair.
// - The deduct multiply subtracts the product from the pair.
`timescale 1ns/1ps
`include "pqu_map.vh"

module pqu_top (
  input  wire                 clk,               // Core clock
  input  wire                 reset_n,           // Async reset, active low
  input  wire                 issue_valid,       // Instruction offered
  input  wire [`PQU_OP_W-1:0] issue_op,          // Operation code
  input  wire                 issue_signed,      // Signed operands
  input  wire [4:0]           issue_dest,        // Destination register
  input  wire [31:0]          first_operand,     // Wide side / dividend
  input  wire [31:0]          second_operand,    // Narrow side / divisor
  output reg                  issue_ready,       // Issue taken this cycle
  output reg                  gpr_wr_valid,      // Register write pulse
  output reg  [4:0]           gpr_wr_dest,       // Register write index
  output reg  [31:0]          gpr_wr_data,       // Register write data
  output reg  [31:0]          upper_result_reg,  // Upper half of pair
  output reg  [31:0]          bottom_result_reg, // Bottom half of pair
  output reg                  quotient_busy      // Division in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Second pass
  reg                     p2_pend;
  reg [`PQU_OP_W-1:0]     p2_op;
  reg [4:0]               p2_dest;
  reg [`PQU_MCAND_W-1:0]  p2_mcand;
  reg [`PQU_MPLIER_W-1:0] p2_upper;
  reg [63:0]              p2_low;
  // Register write stage
  reg                     s1_valid;
  reg [4:0]               s1_dest;
  reg [31:0]              s1_data;
  // Divider
  reg [5:0]               div_cnt;
  reg [5:0]               div_iter;
  reg [32:0]              div_rem;
  reg [31:0]              div_quo;
  reg [31:0]              div_dvs;
  reg                     div_neg_q;
  reg                     div_neg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Issue decode
  wire issue_go = issue_valid & issue_ready;
  wire op_mul   = (issue_op == `PQU_OP_PAIR) | (issue_op == `PQU_OP_ACC) |
                  (issue_op == `PQU_OP_DED) | (issue_op == `PQU_OP_GPR);
  wire op_quo   = (issue_op == `PQU_OP_QUO);
  wire op_move  = (issue_op == `PQU_OP_MFU) | (issue_op == `PQU_OP_MFB);

  // Narrow side fits in 16 bits
  wire narrow_short = issue_signed ?
                      (second_operand[31:15] == {17{second_operand[15]}}) :
                      (second_operand[31:16] == 16'h0000);
  // Full-width multiply taken: needs a second pass
  wire full_go = issue_go & op_mul & ~narrow_short;

  ////////////////////////////////////////////////////////////////////////////
  // Shared multiplier
  reg  [`PQU_MCAND_W-1:0]  mul_a;
  reg  [`PQU_MPLIER_W-1:0] mul_b;
  wire [`PQU_PROD_W-1:0]   mul_p;

  always @* begin
    if (p2_pend) begin
      mul_a = p2_mcand;
      mul_b = p2_upper;
    end else begin
      mul_a = {issue_signed & first_operand[31], first_operand};
      // First pass of a full multiply takes the low half unsigned
      mul_b = {issue_signed & narrow_short & second_operand[15],
               second_operand[15:0]};
    end
  end

  pqu_mul_pass u_mul (
    .mcand  (mul_a),
    .mplier (mul_b),
    .prod   (mul_p)
  );

  wire [63:0] mul_p64 = {{(64-`PQU_PROD_W){mul_p[`PQU_PROD_W-1]}}, mul_p};
  // Second pass adds the upper-half partial, shifted
  wire [63:0] mul_val = p2_pend ? (p2_low + {mul_p64[47:0], 16'h0000}) : mul_p64;
  wire        mul_fin = p2_pend | (issue_go & op_mul & narrow_short);
  wire [`PQU_OP_W-1:0] mul_op   = p2_pend ? p2_op : issue_op;
  wire [4:0]           mul_dest = p2_pend ? p2_dest : issue_dest;

  ////////////////////////////////////////////////////////////////////////////
  // Divider step
  // Restoring step; bit 32 of the trial flags a borrow
  wire        div_fin  = quotient_busy & (div_cnt == 6'h01);
  wire [32:0] div_shft = {div_rem[31:0], div_quo[31]};
  wire [32:0] div_tri  = div_shft - {1'b0, div_dvs};
  wire        div_step = (div_iter != 6'h00);
  wire [32:0] eff_rem  = div_step ? (div_tri[32] ? div_shft : div_tri) : div_rem;
  wire [31:0] eff_quo  = div_step ? {div_quo[30:0], ~div_tri[32]} : div_quo;
  wire [31:0] fin_q    = div_neg_q ? (32'h00000000 - eff_quo) : eff_quo;
  wire [31:0] fin_r    = div_neg_r ? (32'h00000000 - eff_rem[31:0]) : eff_rem[31:0];

  // Pair as seen this cycle, with a finishing divide folded in
  wire [31:0] pair_up  = div_fin ? fin_r : upper_result_reg;
  wire [31:0] pair_bot = div_fin ? fin_q : bottom_result_reg;
  wire [63:0] pair_now = {pair_up, pair_bot};

  ////////////////////////////////////////////////////////////////////////////
  // Early-in size detection for a new divide
  // Signed fit: all bits above the field equal its top bit
  wire        a_neg = issue_signed & first_operand[31];
  wire        b_neg = issue_signed & second_operand[31];
  wire [31:0] mag_a = a_neg ? (32'h00000000 - first_operand) : first_operand;
  wire [31:0] mag_b = b_neg ? (32'h00000000 - second_operand) : second_operand;
  wire fits8  = issue_signed ? (first_operand[31:7] == {25{first_operand[7]}}) :
                               (first_operand[31:8] == 24'h000000);
  wire fits16 = issue_signed ? (first_operand[31:15] == {17{first_operand[15]}}) :
                               (first_operand[31:16] == 16'h0000);
  wire fits24 = issue_signed ? (first_operand[31:23] == {9{first_operand[23]}}) :
                               (first_operand[31:24] == 8'h00);

  reg [5:0] new_skip;
  reg [5:0] new_lat;

  always @* begin
    if (fits8) begin
      new_skip = `PQU_SKIP8;
      new_lat  = `PQU_LAT8;
    end else if (fits16) begin
      new_skip = `PQU_SKIP16;
      new_lat  = `PQU_LAT16;
    end else if (fits24) begin
      new_skip = `PQU_SKIP24;
      new_lat  = `PQU_LAT24;
    end else begin
      new_skip = `PQU_SKIP32;
      new_lat  = `PQU_LAT32;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issue readiness
  reg next_ready;

  always @* begin
    next_ready = 1'b1;
    // Ready returns a cycle early so the next issue meets the result
    if (quotient_busy & ~div_fin) begin
      next_ready = (div_cnt == 6'h02);
    end
    if (issue_go & op_quo) begin
      next_ready = 1'b0;
    end
    if (full_go) begin
      next_ready = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair update
  // Accumulate bases on pair_now, so a finishing divide counts
  reg [63:0] next_pair;

  always @* begin
    next_pair = {upper_result_reg, bottom_result_reg};
    if (div_fin) begin
      next_pair = pair_now;
    end
    if (mul_fin) begin
      case (mul_op)
        `PQU_OP_PAIR: next_pair = mul_val;
        `PQU_OP_ACC:  next_pair = pair_now + mul_val;
        `PQU_OP_DED:  next_pair = pair_now - mul_val;
        default:      next_pair = pair_now;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write path, two stages
  // Moves share the output stage with the targeted multiply
  reg        next_s1_valid;
  reg [31:0] next_s1_data;
  reg [4:0]  next_s1_dest;

  always @* begin
    next_s1_valid = 1'b0;
    next_s1_data  = `PQU_RST_WORD;
    next_s1_dest  = mul_dest;
    if (mul_fin & (mul_op == `PQU_OP_GPR)) begin
      next_s1_valid = 1'b1;
      next_s1_data  = mul_val[31:0];
    end else if (issue_go & op_move) begin
      next_s1_valid = 1'b1;
      next_s1_data  = (issue_op == `PQU_OP_MFU) ? pair_up : pair_bot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair, issue handshake and register write stages
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      issue_ready       <= 1'b1;
      upper_result_reg  <= `PQU_RST_WORD;
      bottom_result_reg <= `PQU_RST_WORD;
      gpr_wr_valid      <= 1'b0;
      gpr_wr_dest       <= `PQU_RST_DEST;
      gpr_wr_data       <= `PQU_RST_WORD;
      s1_valid          <= 1'b0;
      s1_dest           <= `PQU_RST_DEST;
      s1_data           <= `PQU_RST_WORD;
    end else begin
      issue_ready       <= next_ready;
      upper_result_reg  <= next_pair[63:32];
      bottom_result_reg <= next_pair[31:0];
      s1_valid          <= next_s1_valid;
      s1_data           <= next_s1_data;
      s1_dest           <= next_s1_dest;
      gpr_wr_valid      <= s1_valid;
      gpr_wr_data       <= s1_data;
      gpr_wr_dest       <= s1_dest;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second multiplier pass for a full-width narrow side
  // Low partial kept whole so the second pass needs one adder only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p2_pend  <= 1'b0;
      p2_op    <= `PQU_OP_PAIR;
      p2_dest  <= `PQU_RST_DEST;
      p2_mcand <= {`PQU_MCAND_W{1'b0}};
      p2_upper <= {`PQU_MPLIER_W{1'b0}};
      p2_low   <= 64'h0000000000000000;
    end else begin
      p2_pend <= full_go;
      if (full_go) begin
        p2_op    <= issue_op;
        p2_dest  <= issue_dest;
        p2_mcand <= mul_a;
        p2_upper <= {issue_signed & second_operand[31], second_operand[31:16]};
        p2_low   <= mul_p64;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider sequencer, free of the integer pipeline
  // Count padded to the tabled latency even when iterations end early
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quotient_busy <= 1'b0;
      div_cnt       <= 6'h00;
      div_iter      <= 6'h00;
      div_rem       <= 33'h000000000;
      div_quo       <= `PQU_RST_WORD;
      div_dvs       <= `PQU_RST_WORD;
      div_neg_q     <= 1'b0;
      div_neg_r     <= 1'b0;
    end else begin
      if (quotient_busy) begin
        div_cnt <= div_cnt - 6'h01;
        div_rem <= eff_rem;
        div_quo <= eff_quo;
        if (div_step) begin
          div_iter <= div_iter - 6'h01;
        end
        if (div_fin) begin
          quotient_busy <= 1'b0;
        end
      end
      // New divide in the finishing cycle wins over the clear
      if (issue_go & op_quo) begin
        quotient_busy <= 1'b1;
        div_cnt       <= new_lat - 6'h01;
        div_iter      <= `PQU_DIV_BITS - new_skip;
        div_rem       <= 33'h000000000;
        div_quo       <= mag_a << new_skip;
        div_dvs       <= mag_b;
        div_neg_q     <= a_neg ^ b_neg;
        div_neg_r     <= a_neg;
      end
    end
  end

endmodule // pqu_top

// File: testbench/pqu_chk.sv
`timescale 1ns/1ps
`include "pqu_map.vh"

module pqu_chk (
  input logic        clk,               // Clock
  input logic        reset_n,           // Reset
  input logic        issue_valid,       // Offer
  input logic [2:0]  issue_op,          // Op
  input logic        issue_signed,      // Signed
  input logic [4:0]  issue_dest,        // Dest
  input logic [31:0] first_operand,     // Wide
  input logic [31:0] second_operand,    // Narrow
  input logic        issue_ready,       // Taken
  input logic        gpr_wr_valid,      // Write
  input logic [4:0]  gpr_wr_dest,       // Index
  input logic [31:0] gpr_wr_data,       // Data
  input logic [31:0] upper_result_reg,  // Upper
  input logic [31:0] bottom_result_reg, // Bottom
  input logic        quotient_busy      // Busy
);
  logic        tk;
  logic        sh;
  logic        mul;
  logic [63:0] pd;
  logic [63:0] pr;
  logic [31:0] pl;
  logic [5:0]  lat;
  logic [5:0]  cnt;
  function automatic logic [5:0] dlat(logic s, logic [31:0] a);
    if (s ? (&a[31:7] || ~|a[31:7]) : ~|a[31:8]) return `PQU_LAT8;
    if (s ? (&a[31:15] || ~|a[31:15]) : ~|a[31:16]) return `PQU_LAT16;
    if (s ? (&a[31:23] || ~|a[31:23]) : ~|a[31:24]) return `PQU_LAT24;
    return `PQU_LAT32;
  endfunction
  assign tk = issue_valid && issue_ready;
  assign sh = issue_signed ? (&second_operand[31:15] || ~|second_operand[31:15])
                           : ~|second_operand[31:16];
  assign mul = issue_op < `PQU_OP_QUO;
  assign pd = issue_signed ? {{32{first_operand[31]}}, first_operand}
                             * {{32{second_operand[31]}}, second_operand}
                           : {32'h0, first_operand} * {32'h0, second_operand};
  assign pl = pd[31:0];
  assign pr = {upper_result_reg, bottom_result_reg};
  // Cycles since the divide was taken
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 6'h00;
      lat <= 6'h00;
    end else if (tk && issue_op == `PQU_OP_QUO) begin
      cnt <= 6'h01;
      lat <= dlat(issue_signed, first_operand);
    end else if (quotient_busy) begin
      cnt <= cnt + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  short_pair_a: assert property (tk && issue_op == `PQU_OP_PAIR && sh |=> pr == $past(pd))
    else $error("short product wrong");
  full_pair_a: assert property (tk && issue_op == `PQU_OP_PAIR && !sh |=> ##1 pr == $past(pd, 2))
    else $error("full product wrong");
  full_gap_a: assert property (tk && mul && !sh |=> !issue_ready)
    else $error("full multiply not held off");
  short_rate_a: assert property (tk && mul && sh |=> issue_ready)
    else $error("short multiply stalled");
  gpr_short_a: assert property (tk && issue_op == `PQU_OP_GPR && sh |=> ##1
    gpr_wr_valid && gpr_wr_data == $past(pl, 2) && gpr_wr_dest == $past(issue_dest, 2))
    else $error("register write wrong");
  div_busy_a: assert property (tk && issue_op == `PQU_OP_QUO |=> quotient_busy && !issue_ready)
    else $error("divide not blocking");
  div_ready_a: assert property ($rose(issue_ready) && quotient_busy |-> cnt == lat - 6'h01)
    else $error("divide repeat wrong");
  div_done_a: assert property ($fell(quotient_busy) |-> cnt == lat)
    else $error("divide latency wrong");
  move_wr_a: assert property (tk && issue_op inside {`PQU_OP_MFU, `PQU_OP_MFB} |=> ##1
    gpr_wr_valid && gpr_wr_dest == $past(issue_dest, 2))
    else $error("move write wrong");
endmodule // pqu_chk

// File: testbench/pqu_pipe.sv
`timescale 1ns/1ps

module pqu_pipe (
  input  wire        clk,            // Clock
  input  wire        issue_ready,    // Taken
  output reg         issue_valid,    // Offer
  output reg  [2:0]  issue_op,       // Op
  output reg         issue_signed,   // Signed
  output reg  [4:0]  issue_dest,     // Dest
  output reg  [31:0] first_operand,  // Wide
  output reg  [31:0] second_operand  // Narrow
);
  int n;
  initial begin
    {issue_valid, issue_op, issue_signed, issue_dest} = 0;
    {first_operand, second_operand} = 0;
  end
  // Offer at an edge, hold until taken
  task automatic issue(input logic [2:0] o, input logic s, input logic [4:0] d,
                       input logic [31:0] a, input logic [31:0] b);
    issue_valid <= 1'b1;
    issue_op <= o;
    issue_signed <= s;
    issue_dest <= d;
    first_operand <= a;
    second_operand <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!issue_ready && n < 40);
    if (!issue_ready) begin
      pqu_top_tb.fail_count++;
      pqu_top_tb.wrap_up;
    end
  endtask
  // Pipeline stalled: nothing offered, lines scrambled
  task rest;
    issue_valid <= 1'b0;
    first_operand <= ~first_operand;
    second_operand <= ~second_operand;
  endtask
endmodule // pqu_pipe

// File: testbench/pqu_top_tb.sv
`timescale 1ns/1ps
`include "pqu_map.vh"

module pqu_top_tb;
  logic        clk;
  logic        reset_n;
  wire         issue_valid, issue_signed, issue_ready, gpr_wr_valid, quotient_busy;
  wire  [2:0]  issue_op;
  wire  [4:0]  issue_dest, gpr_wr_dest;
  wire  [31:0] first_operand, second_operand, gpr_wr_data;
  wire  [31:0] upper_result_reg, bottom_result_reg;
  wire  [63:0] pr = {upper_result_reg, bottom_result_reg};
  int          fail_count;
  int          cmp_count;

  pqu_pipe p (.clk, .issue_ready, .issue_valid, .issue_op, .issue_signed, .issue_dest,
    .first_operand, .second_operand);
  pqu_top i_dut (.clk, .reset_n, .issue_valid, .issue_op, .issue_signed, .issue_dest,
    .first_operand, .second_operand, .issue_ready, .gpr_wr_valid, .gpr_wr_dest,
    .gpr_wr_data, .upper_result_reg, .bottom_result_reg, .quotient_busy);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string w, logic [63:0] e, logic [63:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", w, e, s);
    end
  endtask
  function automatic logic [63:0] prd(logic s, logic [31:0] a, logic [31:0] b);
    return s ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
  endfunction
  task cyc(int k);
    repeat (k) @(posedge clk);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_mul;
    logic [63:0] e;
    p.issue(`PQU_OP_PAIR, 1'b1, 5'h00, 32'h80000001, 32'hFFFF8000);
    p.issue(`PQU_OP_PAIR, 1'b0, 5'h00, 32'hFFFFFFFF, 32'h0000FFFF);
    chk("short repeat", 1, p.n);
    chk("short pair", prd(1'b1, 32'h80000001, 32'hFFFF8000), pr);
    e = prd(1'b0, 32'hFFFFFFFF, 32'h0000FFFF);
    p.issue(`PQU_OP_ACC, 1'b1, 5'h00, 32'h12345678, 32'h87654321);
    chk("pair second", e, pr);
    e = e + prd(1'b1, 32'h12345678, 32'h87654321);
    p.issue(`PQU_OP_DED, 1'b0, 5'h00, 32'h0000FFFF, 32'h00010000);
    chk("full repeat", 2, p.n);
    chk("accumulate", e, pr);
    e = e - prd(1'b0, 32'h0000FFFF, 32'h00010000);
    p.rest;
    cyc(2);
    chk("deduct", e, pr);
    p.issue(`PQU_OP_PAIR, 1'b1, 5'h00, 32'hFEDCBA98, 32'h80000000);
    p.rest;
    cyc(2);
    chk("full pair", prd(1'b1, 32'hFEDCBA98, 32'h80000000), pr);
  endtask
  task t_gpr;
    logic [63:0] q;
    logic [63:0] e;
    q = pr;
    for (int i = 0; i < 2; i++) begin
      e = prd(1'b1, 32'h00001234, i ? 32'h40000003 : 32'hFFFFFFFE);
      p.issue(`PQU_OP_GPR, 1'b1, 5'(7 + i), 32'h00001234, i ? 32'h40000003 : 32'hFFFFFFFE);
      p.rest;
      cyc(2 + i);
      chk("gpr valid", 1, gpr_wr_valid);
      chk("gpr dest", 7 + i, gpr_wr_dest);
      chk("gpr data", e[31:0], gpr_wr_data);
      chk("pair kept", q, pr);
    end
  endtask
  task automatic t_div;
    logic [31:0] a [4] = '{32'hFFFFFF85, 32'h0000ABCD, 32'hFF800001, 32'h9ABCDEF0};
    logic [31:0] b [4] = '{32'h00000007, 32'h0000000D, 32'hFFFFFFFD, 32'h00001234};
    int          l [4] = '{12, 19, 26, 33};
    logic [31:0] eq;
    logic [31:0] er;
    for (int i = 0; i < 4; i++) begin
      eq = $signed(a[i]) / $signed(b[i]);
      er = $signed(a[i]) % $signed(b[i]);
      if (i[0]) begin
        eq = a[i] / b[i];
        er = a[i] % b[i];
      end
      p.issue(`PQU_OP_QUO, !i[0], 5'h00, a[i], b[i]);
      p.issue(`PQU_OP_MFB, 1'b0, 5'h03, 32'h0, 32'h0);
      chk("div repeat", l[i] - 1, p.n);
      chk("div busy", 1, quotient_busy);
      p.issue(`PQU_OP_MFU, 1'b0, 5'h04, 32'h0, 32'h0);
      chk("div pair", {er, eq}, pr);
      chk("div idle", 0, quotient_busy);
      p.rest;
      cyc(1);
      chk("move bottom", {5'h03, eq}, {gpr_wr_dest, gpr_wr_data});
      cyc(1);
      chk("move upper", {5'h04, er}, {gpr_wr_dest, gpr_wr_data});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("reset pair", 64'h0, pr);
    t_mul;
    t_gpr;
    t_div;
    wrap_up;
  end
endmodule // pqu_top_tb

bind pqu_top pqu_chk i_chk (.clk, .reset_n, .issue_valid, .issue_op, .issue_signed,
  .issue_dest, .first_operand, .second_operand, .issue_ready, .gpr_wr_valid, .gpr_wr_dest,
  .gpr_wr_data, .upper_result_reg, .bottom_result_reg, .quotient_busy);
